// >>> common/eas_defines.vh
/*
 * Constants of the eight-bit arithmetic and shift datapath: register map,
 * field layout, reset values and operation codes.
 * Assumes it is included by its bare name from each design file.
 */
`ifndef EAS_DEFINES_VH
`define EAS_DEFINES_VH

`define EAS_ADDR_W 5
`define EAS_OFF_CTRL 5'h00
`define EAS_OFF_OPND 5'h04
`define EAS_OFF_WREG 5'h08
`define EAS_OFF_FLAGS 5'h0C
`define EAS_OFF_RESULT 5'h10

`define EAS_RESP_OKAY 2'b00
`define EAS_RESP_SLVERR 2'b10

`define EAS_BYTE_ZERO 8'h00
`define EAS_BYTE_ONE 8'h01
`define EAS_FLAGS_RST 4'h0
`define EAS_WORD_ZERO 32'h0000_0000

`define EAS_FLAG_Z 0
`define EAS_FLAG_C 1
`define EAS_FLAG_NC 2
`define EAS_FLAG_SW 3

`define EAS_OPND_IMM 7:0
`define EAS_OPND_MEM 15:8
`define EAS_CTRL_OP 4:0
`define EAS_RES_DEST 8
`define EAS_WREG_FLD 7:0
`define EAS_FLAGS_FLD 3:0
`define EAS_RES_FLD 7:0
`define EAS_STRB_RST 4'h0

`define EAS_OP_ADD_A_I 5'h00
`define EAS_OP_ADD_A_M 5'h01
`define EAS_OP_ADD_M_A 5'h02
`define EAS_OP_ADDC_A_M 5'h03
`define EAS_OP_ADDC_M_A 5'h04
`define EAS_OP_ADDC_A 5'h05
`define EAS_OP_ADDC_M 5'h06
`define EAS_OP_SUB_A_I 5'h07
`define EAS_OP_SUB_A_M 5'h08
`define EAS_OP_SUB_M_A 5'h09
`define EAS_OP_SUBC_A_M 5'h0A
`define EAS_OP_SUBC_M_A 5'h0B
`define EAS_OP_SUBC_A 5'h0C
`define EAS_OP_SUBC_M 5'h0D
`define EAS_OP_INC_M 5'h0E
`define EAS_OP_DEC_M 5'h0F
`define EAS_OP_CLEAR_M 5'h10
`define EAS_OP_LSHR_A 5'h11
`define EAS_OP_ROTR_A 5'h12
`define EAS_OP_LSHR_M 5'h13
`define EAS_OP_ROTR_M 5'h14
`define EAS_OP_LSHL_A 5'h15
`define EAS_OP_ROTL_A 5'h16
`define EAS_OP_LSHL_M 5'h17
`define EAS_OP_ROTL_M 5'h18
`define EAS_OP_SWAP_A 5'h19

`endif

// >>> core/eas_adder.v
/*
 * Eight-bit adder with nibble carry and signed overflow, used for both
 * addition and subtraction by two's complement.
 * Assumes purely combinational use inside the datapath top.
 */
`timescale 1ns/1ps
`include "eas_defines.vh"

module eas_adder (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    input wire sub,
    output wire [7:0] sum,
    output wire carry,
    output wire nibble_carry,
    output wire overflow
);
    wire [7:0] bx;
    wire ci;
    wire [8:0] full;
    wire [4:0] low;

    // Subtraction adds the complement; carry in is the inverted borrow
    assign bx = sub ? ~b : b;
    assign ci = sub ? ~cin : cin;
    assign full = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
    assign low = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    assign sum = full[7:0];
    // On subtract the flags report borrow, not carry
    assign carry = sub ? ~full[8] : full[8];
    assign nibble_carry = sub ? ~low[4] : low[4];
    assign overflow = (a[7] == bx[7]) & (full[7] != a[7]);
endmodule // eas_adder

// >>> core/eas_alu_shifter.v
/*
 * Eight-bit arithmetic and shift datapath with working register and flags,
 * controlled over AXI4-Lite. A write to the control register with wr_strb[0] set
 * and a known op code runs one operation; results bound for memory leave on mem_we / mem_wdata.
 * Assumes one clock, synchronous active-low reset, one write and one read
 * outstanding at most.
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "eas_defines.vh"

module eas_alu_shifter (
    input wire clk,
    input wire resetn,
    input wire [`EAS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`EAS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg mem_we,
    output reg [7:0] mem_wdata
);
    // Write channel holding registers
    reg aw_held_reg;
    reg [`EAS_ADDR_W-1:0] aw_addr_reg;
    reg w_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    // Datapath state
    reg [7:0] working_register;
    reg [3:0] flags_reg;
    reg [7:0] imm_reg;
    reg [7:0] mem_opnd_reg;
    reg [7:0] result_reg;
    reg result_dest_reg;

    wire aw_take;
    wire w_take;
    wire wr_do;
    wire [`EAS_ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_mapped;
    wire ar_take;
    wire rd_mapped;
    wire run_op;
    wire [4:0] op_code;

    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;

    // Address and data may arrive in either order, or together
    assign wr_do = (aw_held_reg | aw_take) & (w_held_reg | w_take);
    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    assign wr_mapped = (wr_addr == `EAS_OFF_CTRL) |
        (wr_addr == `EAS_OFF_OPND) | (wr_addr == `EAS_OFF_WREG) |
        (wr_addr == `EAS_OFF_FLAGS) | (wr_addr == `EAS_OFF_RESULT);

    assign run_op = wr_do & (wr_addr == `EAS_OFF_CTRL) & wr_strb[0];
    assign op_code = wr_data[`EAS_CTRL_OP];

    // Operand selection for the shared adder
    reg [7:0] add_a;
    reg [7:0] add_b;
    reg add_cin;
    reg add_sub;
    wire [7:0] add_sum;
    wire add_c;
    wire add_nc;
    wire add_sw;

    always @* begin
        add_a = working_register;
        add_b = `EAS_BYTE_ZERO;
        add_cin = 1'b0;
        add_sub = 1'b0;
        case (op_code)
            `EAS_OP_ADD_A_I: begin
                add_b = imm_reg;
            end
            `EAS_OP_ADD_A_M, `EAS_OP_ADD_M_A: begin
                add_b = mem_opnd_reg;
            end
            `EAS_OP_ADDC_A_M, `EAS_OP_ADDC_M_A: begin
                add_b = mem_opnd_reg;
                add_cin = flags_reg[`EAS_FLAG_C];
            end
            `EAS_OP_ADDC_A: begin
                add_cin = flags_reg[`EAS_FLAG_C];
            end
            `EAS_OP_ADDC_M: begin
                add_a = mem_opnd_reg;
                add_cin = flags_reg[`EAS_FLAG_C];
            end
            `EAS_OP_SUB_A_I: begin
                add_b = imm_reg;
                add_sub = 1'b1;
            end
            `EAS_OP_SUB_A_M: begin
                add_b = mem_opnd_reg;
                add_sub = 1'b1;
            end
            `EAS_OP_SUB_M_A: begin
                add_a = mem_opnd_reg;
                add_b = working_register;
                add_sub = 1'b1;
            end
            `EAS_OP_SUBC_A_M: begin
                add_b = mem_opnd_reg;
                add_cin = flags_reg[`EAS_FLAG_C];
                add_sub = 1'b1;
            end
            `EAS_OP_SUBC_M_A: begin
                add_a = mem_opnd_reg;
                add_b = working_register;
                add_cin = flags_reg[`EAS_FLAG_C];
                add_sub = 1'b1;
            end
            `EAS_OP_SUBC_A: begin
                add_cin = flags_reg[`EAS_FLAG_C];
                add_sub = 1'b1;
            end
            `EAS_OP_SUBC_M: begin
                add_a = mem_opnd_reg;
                add_cin = flags_reg[`EAS_FLAG_C];
                add_sub = 1'b1;
            end
            `EAS_OP_INC_M: begin
                add_a = mem_opnd_reg;
                add_b = `EAS_BYTE_ONE;
            end
            `EAS_OP_DEC_M: begin
                add_a = mem_opnd_reg;
                add_b = `EAS_BYTE_ONE;
                add_sub = 1'b1;
            end
            default: begin
                add_a = working_register;
            end
        endcase
    end

    eas_adder u_adder (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sub(add_sub),
        .sum(add_sum),
        .carry(add_c),
        .nibble_carry(add_nc),
        .overflow(add_sw)
    );

    // Result, destination and flag update of the requested operation
    reg [7:0] op_res;
    reg op_to_mem;
    reg op_known;
    reg [3:0] op_flags;
    wire [3:0] arith_flags;
    wire cy;
    wire [7:0] wrk;
    wire [7:0] mem;

    assign cy = flags_reg[`EAS_FLAG_C];
    assign wrk = working_register;
    assign mem = mem_opnd_reg;
    // Flag bit order: overflow, nibble carry, carry, zero
    assign arith_flags = {add_sw, add_nc, add_c,
        add_sum == `EAS_BYTE_ZERO};

    always @* begin
        op_res = add_sum;
        op_to_mem = 1'b0;
        op_known = 1'b1;
        op_flags = arith_flags;
        case (op_code)
            `EAS_OP_ADD_A_I, `EAS_OP_ADD_A_M, `EAS_OP_ADDC_A_M,
            `EAS_OP_ADDC_A, `EAS_OP_SUB_A_I, `EAS_OP_SUB_A_M,
            `EAS_OP_SUBC_A_M, `EAS_OP_SUBC_A: begin
                op_to_mem = 1'b0;
            end
            `EAS_OP_ADD_M_A, `EAS_OP_ADDC_M_A, `EAS_OP_ADDC_M,
            `EAS_OP_SUB_M_A, `EAS_OP_SUBC_M_A, `EAS_OP_SUBC_M,
            `EAS_OP_INC_M, `EAS_OP_DEC_M: begin
                op_to_mem = 1'b1;
            end
            `EAS_OP_CLEAR_M: begin
                op_res = `EAS_BYTE_ZERO;
                op_to_mem = 1'b1;
                op_flags = flags_reg;
            end
            `EAS_OP_LSHR_A: begin
                op_res = {1'b0, wrk[7:1]};
                op_flags = {flags_reg[3:2], wrk[0], flags_reg[0]};
            end
            `EAS_OP_ROTR_A: begin
                op_res = {cy, wrk[7:1]};
                op_flags = {flags_reg[3:2], wrk[0], flags_reg[0]};
            end
            `EAS_OP_LSHR_M: begin
                op_res = {1'b0, mem[7:1]};
                op_to_mem = 1'b1;
                op_flags = {flags_reg[3:2], mem[0], flags_reg[0]};
            end
            `EAS_OP_ROTR_M: begin
                op_res = {cy, mem[7:1]};
                op_to_mem = 1'b1;
                op_flags = {flags_reg[3:2], mem[0], flags_reg[0]};
            end
            `EAS_OP_LSHL_A: begin
                op_res = {wrk[6:0], 1'b0};
                op_flags = {flags_reg[3:2], wrk[7], flags_reg[0]};
            end
            `EAS_OP_ROTL_A: begin
                op_res = {wrk[6:0], cy};
                op_flags = {flags_reg[3:2], wrk[7], flags_reg[0]};
            end
            `EAS_OP_LSHL_M: begin
                op_res = {mem[6:0], 1'b0};
                op_to_mem = 1'b1;
                op_flags = {flags_reg[3:2], mem[7], flags_reg[0]};
            end
            `EAS_OP_ROTL_M: begin
                op_res = {mem[6:0], cy};
                op_to_mem = 1'b1;
                op_flags = {flags_reg[3:2], mem[7], flags_reg[0]};
            end
            `EAS_OP_SWAP_A: begin
                op_res = {wrk[3:0], wrk[7:4]};
                op_flags = flags_reg;
            end
            default: begin
                op_known = 1'b0;
                op_flags = flags_reg;
            end
        endcase
    end

    // Write channel and register updates
    always @(posedge clk) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= {`EAS_ADDR_W{1'b0}};
            w_held_reg <= 1'b0;
            w_data_reg <= `EAS_WORD_ZERO;
            w_strb_reg <= `EAS_STRB_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EAS_RESP_OKAY;
            working_register <= `EAS_BYTE_ZERO;
            flags_reg <= `EAS_FLAGS_RST;
            imm_reg <= `EAS_BYTE_ZERO;
            mem_opnd_reg <= `EAS_BYTE_ZERO;
            result_reg <= `EAS_BYTE_ZERO;
            result_dest_reg <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= `EAS_BYTE_ZERO;
        end else begin
            mem_we <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? `EAS_RESP_OKAY
                                         : `EAS_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
            end
            if (wr_do && wr_addr == `EAS_OFF_OPND) begin
                if (wr_strb[0]) begin
                    imm_reg <= wr_data[`EAS_OPND_IMM];
                end
                if (wr_strb[1]) begin
                    mem_opnd_reg <= wr_data[`EAS_OPND_MEM];
                end
            end
            if (wr_do && wr_addr == `EAS_OFF_WREG && wr_strb[0]) begin
                working_register <= wr_data[`EAS_WREG_FLD];
            end
            if (wr_do && wr_addr == `EAS_OFF_FLAGS && wr_strb[0]) begin
                flags_reg <= wr_data[`EAS_FLAGS_FLD];
            end
            // Result and flags land on the same edge
            if (run_op && op_known) begin
                flags_reg <= op_flags;
                result_reg <= op_res;
                result_dest_reg <= op_to_mem;
                if (op_to_mem) begin
                    mem_we <= 1'b1;
                    mem_wdata <= op_res;
                    mem_opnd_reg <= op_res;
                end else begin
                    working_register <= op_res;
                end
            end
        end
    end

    // Read channel
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rd_mapped = (s_axi_araddr == `EAS_OFF_CTRL) |
        (s_axi_araddr == `EAS_OFF_OPND) | (s_axi_araddr == `EAS_OFF_WREG) |
        (s_axi_araddr == `EAS_OFF_FLAGS) |
        (s_axi_araddr == `EAS_OFF_RESULT);

    reg [31:0] rd_word;

    always @* begin
        rd_word = `EAS_WORD_ZERO;
        case (s_axi_araddr)
            `EAS_OFF_OPND: begin
                rd_word[`EAS_OPND_IMM] = imm_reg;
                rd_word[`EAS_OPND_MEM] = mem_opnd_reg;
            end
            `EAS_OFF_WREG: begin
                rd_word[`EAS_WREG_FLD] = working_register;
            end
            `EAS_OFF_FLAGS: begin
                rd_word[`EAS_FLAGS_FLD] = flags_reg;
            end
            `EAS_OFF_RESULT: begin
                rd_word[`EAS_RES_FLD] = result_reg;
                rd_word[`EAS_RES_DEST] = result_dest_reg;
            end
            default: begin
                rd_word = `EAS_WORD_ZERO;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `EAS_WORD_ZERO;
            s_axi_rresp <= `EAS_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? `EAS_RESP_OKAY : `EAS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // eas_alu_shifter

// >>> test/eas_alu_shifter_props.sv
/*
 * Checker for the datapath top: op commit timing and bus answers.
 * Assumes aw and w are offered together by the master.
 */
`timescale 1ns/1ps
`include "eas_defines.vh"

module eas_alu_shifter_props (
    input wire clk,
    input wire resetn,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire mem_we,
    input wire [7:0] mem_wdata
);
    localparam [31:0] MEM_OPS = 32'h0199_EA54;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    wire ctrl_take = wr_take && s_axi_awaddr == `EAS_OFF_CTRL
        && s_axi_wstrb[0];
    wire mapped_w = s_axi_awaddr inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
    wire mapped_r = s_axi_araddr inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10};
    sequence s_mem_op;
        ctrl_take ##0 MEM_OPS[s_axi_wdata[4:0]];
    endsequence
    sequence s_mem_commit;
        mem_we && $rose(s_axi_bvalid);
    endsequence
    property p_mem_dest;
        s_mem_op |=> s_mem_commit;
    endproperty
    a_mem_dest: assert property (p_mem_dest)
        else $error("memory result not written with the answer");
    property p_reg_dest;
        ctrl_take && !MEM_OPS[s_axi_wdata[4:0]] |=> !mem_we && s_axi_bvalid;
    endproperty
    a_reg_dest: assert property (p_reg_dest)
        else $error("register op wrote memory");
    property p_clear;
        ctrl_take && s_axi_wdata[4:0] == `EAS_OP_CLEAR_M
            |=> mem_we && mem_wdata == `EAS_BYTE_ZERO;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not write zero");
    property p_mem_pulse;
        mem_we |=> !mem_we;
    endproperty
    a_mem_pulse: assert property (p_mem_pulse)
        else $error("memory write longer than one cycle");
    property p_mem_hold;
        !mem_we && $past(resetn) |-> $stable(mem_wdata);
    endproperty
    a_mem_hold: assert property (p_mem_hold)
        else $error("memory byte changed without a write");
    property p_b_answer;
        wr_take |=> s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer)
        else $error("write answer late");
    property p_w_unmapped;
        wr_take && !mapped_w |=> s_axi_bresp == `EAS_RESP_SLVERR;
    endproperty
    a_w_unmapped: assert property (p_w_unmapped)
        else $error("unmapped write not refused");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read answer late");
    property p_r_unmapped;
        s_axi_arvalid && s_axi_arready && !mapped_r |=> s_axi_rresp ==
            `EAS_RESP_SLVERR && s_axi_rdata == `EAS_WORD_ZERO;
    endproperty
    a_r_unmapped: assert property (p_r_unmapped)
        else $error("unmapped read not refused");
endmodule // eas_alu_shifter_props

bind eas_alu_shifter eas_alu_shifter_props props_u (.clk(clk),
    .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .mem_we(mem_we), .mem_wdata(mem_wdata));

// >>> test/eas_alu_shifter_test.sv
/*
 * Self-checking bench: AXI4-Lite master, reference model of every op,
 * queued expectations checked by a response monitor.
 * Assumes the register map and op codes of the datapath top.
 */
`timescale 1ns/1ps
`include "eas_defines.vh"
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", n, e, s); end end

module eas_alu_shifter_test;
    localparam [31:0] MEM_OPS = 32'h0199_EA54;
    reg clk = 0;
    reg resetn = 0;
    reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0;
    reg [31:0] s_axi_wdata = 0;
    reg [3:0] s_axi_wstrb = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, mem_we;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] mem_wdata, last_byte, wcnt;
    integer error_cnt = 0, comparisons = 0, rr, k;
    reg [34:0] exp_q[$];
    reg [34:0] e;
    reg [31:0] rv;
    reg [7:0] w, m, im, pc;
    reg [3:0] f;
    reg [8:0] res;
    reg [4:0] op;

    eas_alu_shifter dut_u (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_we(mem_we),
        .mem_wdata(mem_wdata));
    eas_mem_model mem_u (.clk(clk), .resetn(resetn), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .last_byte(last_byte), .write_cnt(wcnt));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic wr(input [4:0] a, input [31:0] d, input [3:0] st,
        input [1:0] rs);
        reg ta, tw;
        exp_q.push_back({1'b0, rs, d});
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        ta = 0;
        tw = 0;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (!ta && s_axi_awready === 1'b1) begin
                ta = 1;
                s_axi_awvalid <= 0;
            end
            if (!tw && s_axi_wready === 1'b1) begin
                tw = 1;
                s_axi_wvalid <= 0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask

    task automatic rd(input [4:0] a, input [33:0] x);
        exp_q.push_back({1'b1, x});
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
    endtask

    // Reference model of one op on w, m, im, f; res keeps the last result
    task automatic run_model(input [4:0] o);
        reg [7:0] a, b, bb, r;
        reg s, ci, dm;
        reg [8:0] t;
        reg [4:0] h;
        dm = MEM_OPS[o];
        a = dm ? m : w;
        b = (o == 5'h00 || o == 5'h07) ? im : (o inside {5'h0E, 5'h0F}) ?
            8'h01 : (o inside {[5'h01:5'h04], [5'h08:5'h0B]}) ?
            (dm ? w : m) : 8'h00;
        ci = (o inside {[5'h03:5'h06], [5'h0A:5'h0D]}) ? f[1] : 1'b0;
        s = o inside {[5'h07:5'h0D], 5'h0F};
        if (o < 5'h10) begin
            bb = s ? ~b : b;
            t = a + bb + (ci ^ s);
            h = a[3:0] + bb[3:0] + (ci ^ s);
            r = t[7:0];
            f = {(a[7] == bb[7]) && (r[7] != a[7]), h[4] ^ s, t[8] ^ s,
                r == 8'h00};
        end else if (o inside {[5'h11:5'h14]}) begin
            r = {o[0] ? 1'b0 : f[1], a[7:1]};
            f[1] = a[0];
        end else if (o inside {[5'h15:5'h18]}) begin
            r = {a[6:0], o[0] ? 1'b0 : f[1]};
            f[1] = a[7];
        end else if (o == 5'h19) begin
            r = {a[3:0], a[7:4]};
        end else if (o == 5'h10) begin
            r = 8'h00;
        end else begin
            return;
        end
        res = {dm, r};
        if (dm) m = r;
        else w = r;
    endtask

    always @(posedge clk) begin
        if (resetn && ((s_axi_bvalid && s_axi_bready) ||
            (s_axi_rvalid && s_axi_rready))) begin
            e = exp_q.pop_front();
            if (e[34]) `CHK("read", e[33:0], {s_axi_rresp, s_axi_rdata})
            else `CHK("bresp", e[33:32], s_axi_bresp)
        end
    end

    task report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        error_cnt++;
        report_and_stop;
    end

    initial begin
        rv = $urandom(53);
        repeat (20) @(posedge clk);
        resetn <= 1;
        for (k = 0; k < 5; k++) rd(k * 4, 34'h0);
        rd(5'h14, {`EAS_RESP_SLVERR, `EAS_WORD_ZERO});
        wr(5'h14, 32'h0000_0001, 4'hF, `EAS_RESP_SLVERR);
        wr(`EAS_OFF_RESULT, 32'hFFFF_FFFF, 4'hF, `EAS_RESP_OKAY);
        wr(`EAS_OFF_WREG, 32'h0000_0055, 4'h2, `EAS_RESP_OKAY);
        rd(`EAS_OFF_WREG, 34'h0);
        rd(`EAS_OFF_RESULT, 34'h0);
        for (rr = 0; rr < 4; rr++) begin
            for (k = 0; k < 27; k++) begin
                op = k;
                rv = (rr == 0) ? 32'h0F80_01FF : $urandom;
                {f, m, im, w} = rv[27:0];
                wr(`EAS_OFF_WREG, {24'h00_0000, w}, 4'h1, `EAS_RESP_OKAY);
                wr(`EAS_OFF_OPND, {16'h0000, m, im}, 4'h3, `EAS_RESP_OKAY);
                wr(`EAS_OFF_FLAGS, {28'h000_0000, f}, 4'h1, `EAS_RESP_OKAY);
                pc = wcnt;
                wr(`EAS_OFF_CTRL, {27'h000_0000, op}, 4'h1, `EAS_RESP_OKAY);
                run_model(op);
                rd(`EAS_OFF_WREG, {26'h000_0000, w});
                rd(`EAS_OFF_OPND, {18'h0_0000, m, im});
                rd(`EAS_OFF_FLAGS, {30'h0000_0000, f});
                if (op < 5'h1A) rd(`EAS_OFF_RESULT, {25'h000_0000, res});
                `CHK("writes", pc + MEM_OPS[op], wcnt)
                if (MEM_OPS[op]) `CHK("mem byte", m, last_byte)
            end
        end
        @(posedge clk);
        resetn <= 0;
        @(posedge clk);
        resetn <= 1;
        rd(`EAS_OFF_WREG, 34'h0);
        rd(`EAS_OFF_FLAGS, 34'h0);
        repeat (2) @(posedge clk);
        report_and_stop;
    end
endmodule // eas_alu_shifter_test

// >>> test/eas_mem_model.sv
/*
 * Data memory side of the datapath: keeps the last byte written back
 * and counts the writes.
 * Assumes mem_we is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ps

module eas_mem_model (
    input wire clk,
    input wire resetn,
    input wire mem_we,
    input wire [7:0] mem_wdata,
    output reg [7:0] last_byte,
    output reg [7:0] write_cnt
);
    always @(posedge clk) begin
        if (!resetn) begin
            last_byte <= 8'h00;
            write_cnt <= 8'h00;
        end else if (mem_we) begin
            last_byte <= mem_wdata;
            write_cnt <= write_cnt + 8'h01;
        end
    end
endmodule // eas_mem_model
